// *** design/dual_rx_port_control.sv ***
// Port select, lock policy, lane mode and equalizer control registers.
// Notes on behaviour
// R1 - Lock mode 0: lock shown only while link locked and video active.
// R2 - Lock mode 1: lock shown whenever linked to a serializer.
// R3 - Raw back channel bit passes local input zero straight through.
// R4 - Lane mode 00 auto, 01 two lanes, 10 primary, 11 secondary.
// R5 - Port1 select: writes update port1 copies and shared registers.
// R6 - Port0 select: writes update port0 copies; bit resets to one.
// R7 - Both selects set: reads return port1 contents.
// R8 - Host clears port1 select to read port0 contents.
// R9 - With port1 selected the equalizer register addresses port1.
// R10 - Restart is written one then zero; hardware never clears it.
// R11 - Restart resets adaptation on both ports at once.
// R12 - Floor start bit acts only while floor override is set.
// R13 - Override and floor start: adaptation starts from preset floor.
// R14 - Video disabled flag from serializer turns lock off in mode 0.
// R15 - Dual-link status is read only; host forces mode via lane field.
// R16 - Reserved bits read zero; writes to them have no effect.
////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module dual_rx_port_control (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       link_linked,
	input  wire logic       video_disabled,
	input  wire logic       local_gp_input_zero,
	output logic            rx_lock,
	output logic            raw_backchannel_data,
	output logic [1:0]      link_input_lane_mode,
	output logic            auto_lane_detect,
	output logic            forced_dual_lane,
	output logic            first_port_active,
	output logic            second_port_active,
	output logic            eq_restart,
	output logic            eq_floor_start_p0,
	output logic            eq_floor_start_p1
);
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] rdata;
		logic [1:0] lnk_s1;
		logic [1:0] lnk_s2;
		logic [1:0] gp_s;
		logic       lock;
		logic       raw;
		logic [1:0] mode;
		logic       auto_m;
		logic       dual_m;
		logic       p0;
		logic       p1;
		logic       rst_eq;
		logic       fl0;
		logic       fl1;
	} st_t;
	st_t st_r;
	st_t st_nxt;

	eq_port_if eq0 ();
	eq_port_if eq1 ();

	eq_port_bank u_eq0 (.clk(clk), .rst(rst), .bus(eq0));
	eq_port_bank u_eq1 (.clk(clk), .rst(rst), .bus(eq1));

	function automatic logic floor_active(input logic [7:0] v);
		floor_active = v[rx_ctl_pkg::FLOOR_OVR_BIT]
			& v[rx_ctl_pkg::FLOOR_SET_BIT]; // R12 R13
	endfunction

	logic sel1;
	logic sel0;
	assign sel1 = st_r.ctl[rx_ctl_pkg::SEL1_BIT];
	assign sel0 = st_r.ctl[rx_ctl_pkg::SEL0_BIT];

	// A write with both selects set lands in both copies.
	always_comb begin
		eq0.wr    = reg_wr && reg_addr == rx_ctl_pkg::EQ_TEST_OFS
			&& sel0; // R6
		eq1.wr    = reg_wr && reg_addr == rx_ctl_pkg::EQ_TEST_OFS
			&& sel1; // R5 R9
		eq0.wdata = reg_wdata;
		eq1.wdata = reg_wdata;
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		// Link status and the pin input cross in from outside.
		st_nxt.lnk_s1 = {video_disabled, link_linked};
		st_nxt.lnk_s2 = st_r.lnk_s1;
		st_nxt.gp_s   = {st_r.gp_s[0], local_gp_input_zero};
		if (reg_wr && reg_addr == rx_ctl_pkg::DUAL_RECEIVE_CONTROL_OFS) begin
			st_nxt.ctl = reg_wdata & rx_ctl_pkg::CTL_MASK; // R16
		end
		st_nxt.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				rx_ctl_pkg::DUAL_RECEIVE_CONTROL_OFS: st_nxt.rdata = st_r.ctl;
				rx_ctl_pkg::EQ_TEST_OFS: begin
					st_nxt.rdata = sel1 ? eq1.rdata : eq0.rdata; // R7 R8
				end
				default: st_nxt.rdata = 8'h00;
			endcase
		end
		if (st_r.ctl[rx_ctl_pkg::LOCK_MODE_BIT]) begin
			st_nxt.lock = st_r.lnk_s2[0]; // R2
		end else begin
			st_nxt.lock = st_r.lnk_s2[0] && !st_r.lnk_s2[1]; // R1 R14
		end
		// Raw mode bypasses filtering; only the synchroniser remains.
		st_nxt.raw = st_r.ctl[rx_ctl_pkg::RAW_BC_BIT]
			& st_r.gp_s[1]; // R3
		st_nxt.mode = st_r.ctl[rx_ctl_pkg::MODE_HI_BIT:
			rx_ctl_pkg::MODE_LO_BIT]; // R4 R15
		st_nxt.auto_m = st_nxt.mode == rx_ctl_pkg::MODE_AUTO; // R4
		st_nxt.dual_m = st_nxt.mode == rx_ctl_pkg::MODE_DUAL; // R4
		st_nxt.p0 = st_nxt.mode == rx_ctl_pkg::MODE_PRI
			|| st_nxt.mode != rx_ctl_pkg::MODE_SEC; // R4
		st_nxt.p1 = st_nxt.mode != rx_ctl_pkg::MODE_PRI; // R4
		// Restart is level held; both ports see it whichever is selected.
		st_nxt.rst_eq = eq0.rdata[rx_ctl_pkg::RESTART_BIT]
			| eq1.rdata[rx_ctl_pkg::RESTART_BIT]; // R10 R11
		st_nxt.fl0 = floor_active(eq0.rdata); // R12 R13
		st_nxt.fl1 = floor_active(eq1.rdata); // R12 R13
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
			st_r.ctl <= rx_ctl_pkg::CTL_RESET; // R6
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata            = st_r.rdata;
	assign rx_lock              = st_r.lock;
	assign raw_backchannel_data = st_r.raw;
	assign link_input_lane_mode = st_r.mode;
	assign auto_lane_detect     = st_r.auto_m;
	assign forced_dual_lane     = st_r.dual_m;
	assign first_port_active    = st_r.p0;
	assign second_port_active   = st_r.p1;
	assign eq_restart           = st_r.rst_eq;
	assign eq_floor_start_p0    = st_r.fl0;
	assign eq_floor_start_p1    = st_r.fl1;

	////////////////////////////////////////////////////////////////////
	chk_lock_video: assert property ( // R1
		@(posedge clk) disable iff (rst)
		(!st_r.ctl[6] && st_r.lnk_s2 == 2'h3) |=> !rx_lock)
		else $error("lock shown with video disabled");
	chk_lock_linked: assert property ( // R2
		@(posedge clk) disable iff (rst)
		(st_r.ctl[6] && st_r.lnk_s2[0]) |=> rx_lock)
		else $error("lock missing while linked");
	chk_raw_pass: assert property ( // R3
		@(posedge clk) disable iff (rst)
		!st_r.ctl[5] |=> !raw_backchannel_data)
		else $error("raw data passed while disabled");
	chk_raw_follow: assert property ( // R3
		@(posedge clk) disable iff (rst)
		st_r.ctl[5] |=> raw_backchannel_data == $past(st_r.gp_s[1]))
		else $error("raw data not following the pin");
	chk_mode_follow: assert property ( // R4
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == 8'h34) |-> ##2
		link_input_lane_mode == $past(reg_wdata[4:3], 2))
		else $error("lane mode not following write");
	chk_sel1_write: assert property ( // R5
		@(posedge clk) disable iff (rst)
		(sel1 && reg_wr && reg_addr == 8'h35) |=>
		eq1.rdata == ($past(reg_wdata) & 8'h70))
		else $error("port1 copy not written");
	chk_sel0_write: assert property ( // R6
		@(posedge clk) disable iff (rst)
		(sel0 && reg_wr && reg_addr == 8'h35) |=>
		eq0.rdata == ($past(reg_wdata) & 8'h70))
		else $error("port0 copy not written");
	chk_port0_read: assert property ( // R8
		@(posedge clk) disable iff (rst)
		(!sel1 && reg_rd && reg_addr == 8'h35 && !eq0.wr) |=>
		reg_rdata == eq0.rdata)
		else $error("port0 contents not returned");
	chk_both_read: assert property ( // R7
		@(posedge clk) disable iff (rst)
		(sel1 && reg_rd && reg_addr == 8'h35 && !eq1.wr) |=>
		reg_rdata == eq1.rdata)
		else $error("port1 contents not returned");
	chk_port1_only: assert property ( // R9
		@(posedge clk) disable iff (rst)
		(sel1 && !sel0 && reg_wr && reg_addr == 8'h35) |=>
		eq0.rdata == $past(eq0.rdata))
		else $error("port0 copy written while port1 selected");
	chk_restart_hold0: assert property ( // R10
		@(posedge clk) disable iff (rst)
		(eq0.rdata[6] && !eq0.wr) |=> eq0.rdata[6])
		else $error("port0 restart cleared by hardware");
	chk_restart_hold1: assert property ( // R10
		@(posedge clk) disable iff (rst)
		(eq1.rdata[6] && !eq1.wr) |=> eq1.rdata[6])
		else $error("port1 restart cleared by hardware");
	chk_restart_both: assert property ( // R11
		@(posedge clk) disable iff (rst)
		(eq0.rdata[6] || eq1.rdata[6]) |=> eq_restart)
		else $error("restart not applied");
	chk_floor_gate: assert property ( // R12
		@(posedge clk) disable iff (rst)
		!eq0.rdata[5] |=> !eq_floor_start_p0)
		else $error("floor used without override");
	chk_floor_gate1: assert property ( // R12
		@(posedge clk) disable iff (rst)
		!eq1.rdata[5] |=> !eq_floor_start_p1)
		else $error("port1 floor used without override");
	chk_floor_start0: assert property ( // R13
		@(posedge clk) disable iff (rst)
		(eq0.rdata[5] && eq0.rdata[4]) |=> eq_floor_start_p0)
		else $error("port0 floor start missing");
	chk_floor_start1: assert property ( // R13
		@(posedge clk) disable iff (rst)
		(eq1.rdata[5] && eq1.rdata[4]) |=> eq_floor_start_p1)
		else $error("port1 floor start missing");
	chk_unmapped_zero: assert property ( // R16
		@(posedge clk) disable iff (rst)
		(reg_rd && reg_addr != 8'h34 && reg_addr != 8'h35) |=>
		reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // dual_rx_port_control

// *** design/rx_ctl_pkg.sv ***
// Package holding register offsets, field positions and reset values.
package rx_ctl_pkg;
	localparam logic [7:0] DUAL_RECEIVE_CONTROL_OFS = 8'h34;
	localparam logic [7:0] EQ_TEST_OFS     = 8'h35;
	localparam int LOCK_MODE_BIT  = 6;
	localparam int RAW_BC_BIT     = 5;
	localparam int MODE_HI_BIT    = 4;
	localparam int MODE_LO_BIT    = 3;
	localparam int SEL1_BIT       = 1;
	localparam int SEL0_BIT       = 0;
	localparam int RESTART_BIT    = 6;
	localparam int FLOOR_OVR_BIT  = 5;
	localparam int FLOOR_SET_BIT  = 4;
	localparam logic [7:0] CTL_RESET  = 8'h01;
	localparam logic [7:0] CTL_MASK   = 8'h7B;
	localparam logic [7:0] EQ_RESET   = 8'h00;
	localparam logic [7:0] EQ_MASK    = 8'h70;
	localparam logic [1:0] MODE_AUTO  = 2'h0;
	localparam logic [1:0] MODE_DUAL  = 2'h1;
	localparam logic [1:0] MODE_PRI   = 2'h2;
	localparam logic [1:0] MODE_SEC   = 2'h3;
endpackage

// *** design/eq_port_if.sv ***
// Interface carrying one port's equalizer test register between modules.
`timescale 1ns/1ns
interface eq_port_if;
	logic       wr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctl (output wr, output wdata, input rdata);
	modport bank (input wr, input wdata, output rdata);
endinterface // eq_port_if

// *** design/eq_port_bank.sv ***
// Per-port equalizer test register copy.
`timescale 1ns/1ns
module eq_port_bank (
	input  wire logic clk,
	input  wire logic rst,
	eq_port_if.bank   bus
);
	typedef struct packed {
		logic [7:0] reg_v;
	} st_t;
	st_t st_r;
	st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (bus.wr) begin
			// Reserved bits are never stored, so they read back as zero.
			st_nxt.reg_v = bus.wdata & rx_ctl_pkg::EQ_MASK; // R16
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '{reg_v: rx_ctl_pkg::EQ_RESET};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus.rdata = st_r.reg_v;
endmodule // eq_port_bank

// *** tb/host_model.sv ***
// Host model driving the control block's register bus.
`timescale 1ns/1ns
module host_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// A restart is ended by a second write, since the device never clears it.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
endmodule // host_model

// *** tb/testbench.sv ***
// Self-checking bench for the dual receive port control block.
`timescale 1ns/1ns
module testbench;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;} row_t;
	logic       clk, rst, reg_wr, reg_rd, link_linked, video_disabled;
	logic       local_gp_input_zero, rx_lock, raw_backchannel_data;
	logic       auto_lane_detect, forced_dual_lane, first_port_active;
	logic       second_port_active, eq_restart;
	logic       eq_floor_start_p0, eq_floor_start_p1;
	logic [1:0] link_input_lane_mode;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, e;
	int         bad_count, n_checks, cycles;
	row_t       rows [5] = '{'{8'h34, 8'hFF, 8'h7B}, '{8'h35, 8'hFF, 8'h70},
		'{8'h34, 8'h01, 8'h01}, '{8'h35, 8'h8F, 8'h00}, '{8'h40, 8'h5A, 8'h00}};
	dual_rx_port_control i_dut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .link_linked, .video_disabled,
		.local_gp_input_zero, .rx_lock, .raw_backchannel_data,
		.link_input_lane_mode, .auto_lane_detect, .forced_dual_lane,
		.first_port_active, .second_port_active, .eq_restart,
		.eq_floor_start_p0, .eq_floor_start_p1);
	host_model i_host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// The whole sequence needs well under a thousand cycles.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pins(input logic l, input logic v, input logic g);
		@(posedge clk);
		link_linked <= l;
		video_disabled <= v;
		local_gp_input_zero <= g;
		settle(6);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		link_linked = 1'b0;
		video_disabled = 1'b0;
		local_gp_input_zero = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		i_host.rd(8'h34, d);
		check(d, 8'h01);
		foreach (rows[i]) begin
			i_host.wr(rows[i].a, rows[i].d);
			i_host.rd(rows[i].a, d);
			check(d, rows[i].r);
		end
		i_host.wr(8'h34, 8'h03);
		i_host.rd(8'h35, d);
		check(d, 8'h70);
		i_host.wr(8'h34, 8'h01);
		i_host.rd(8'h35, d);
		check(d, 8'h00);
		check({eq_restart, eq_floor_start_p1, eq_floor_start_p0}, 8'h06);
		i_host.wr(8'h35, 8'h10);
		settle(2);
		check(eq_floor_start_p0, 8'h00);
		i_host.wr(8'h35, 8'h30);
		settle(2);
		check(eq_floor_start_p0, 8'h01);
		i_host.wr(8'h34, 8'h03);
		i_host.wr(8'h35, 8'h00);
		settle(2);
		d = {5'h00, eq_restart, eq_floor_start_p1, eq_floor_start_p0};
		check(d, 8'h00);
		i_host.wr(8'h34, 8'h02);
		i_host.wr(8'h35, 8'h50);
		i_host.rd(8'h35, d);
		check(d, 8'h50);
		d = {5'h00, eq_restart, eq_floor_start_p1, eq_floor_start_p0};
		check(d, 8'h04);
		i_host.wr(8'h34, 8'h00);
		i_host.wr(8'h35, 8'h70);
		i_host.rd(8'h35, d);
		check(d, 8'h00);
		i_host.wr(8'h34, 8'h02);
		i_host.rd(8'h35, d);
		check(d, 8'h50);
		i_host.wr(8'h34, 8'h01);
		i_host.rd(8'h35, d);
		check(d, 8'h00);
		for (int m = 0; m < 4; m++) begin
			i_host.wr(8'h34, {3'h0, 2'(m), 3'h1});
			settle(2);
			e = {2'h0, 2'(m), m == 0, m == 1, m != 3, m != 2};
			d = {2'h0, link_input_lane_mode, auto_lane_detect,
				forced_dual_lane, first_port_active, second_port_active};
			check(d, e);
		end
		i_host.wr(8'h34, 8'h01);
		pins(1'b1, 1'b1, 1'b0);
		check(rx_lock, 8'h00);
		pins(1'b1, 1'b0, 1'b0);
		check(rx_lock, 8'h01);
		i_host.wr(8'h34, 8'h41);
		pins(1'b1, 1'b1, 1'b0);
		check(rx_lock, 8'h01);
		i_host.wr(8'h34, 8'h21);
		pins(1'b1, 1'b0, 1'b1);
		check(raw_backchannel_data, 8'h01);
		pins(1'b1, 1'b0, 1'b0);
		check(raw_backchannel_data, 8'h00);
		@(posedge clk);
		rst <= 1'b1;
		#1;
		check(reg_rdata, 8'h00);
		d = {link_input_lane_mode, rx_lock, raw_backchannel_data,
			auto_lane_detect, forced_dual_lane, first_port_active,
			second_port_active};
		check(d, 8'h00);
		d = {5'h00, eq_restart, eq_floor_start_p1, eq_floor_start_p0};
		check(d, 8'h00);
		@(posedge clk);
		rst <= 1'b0;
		i_host.rd(8'h34, d);
		check(d, 8'h01);
		print_verdict();
	end
endmodule // testbench
